/* File: rtl/atdo_pkg.sv */
// package: constants, modes and carrier structs for the converter control block
//==========================================================================
package atdo_pkg;

    //==========================================================================
    // widths
    localparam int unsigned RES_W  = 12;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ACC_W  = 20;
    localparam int unsigned SRC_N  = 16;

    //==========================================================================
    // timing, in converter clock cycles
    localparam logic [7:0] SMPL_MIN_CYC = 8'h03;
    localparam logic [3:0] CONV_CYC_12  = 4'hC;
    localparam logic [3:0] CONV_CYC_10  = 4'hA;
    localparam logic [3:0] CONV_CYC_8   = 4'h8;
    localparam logic [3:0] CONV_CYC_6   = 4'h6;

    //==========================================================================
    // oversampler limits and reset values
    localparam logic [3:0]        OVS_SHIFT_MAX = 4'h8;
    localparam logic [DATA_W-1:0] DATA_RST      = 16'h0000;

    //==========================================================================
    // modes
    typedef enum logic [1:0] {
        EDGE_OFF  = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } atdo_edge_t;

    typedef enum logic [1:0] {
        RES_12 = 2'h0,
        RES_10 = 2'h1,
        RES_8  = 2'h2,
        RES_6  = 2'h3
    } atdo_res_t;

    //==========================================================================
    // carriers
    typedef struct packed {
        atdo_edge_t trigger_edge_mode;
        logic [3:0] trigger_source_select;
        atdo_res_t  resolution_select;
        logic       converter_on;
        logic       dma_enable;
        logic       eoc_mode_select;
        logic       overrun_irq_enable;
        logic       internal_channels_enable;
        logic       battery_channel_enable;
        logic       oversample_enable;
        logic [2:0] oversample_ratio;
        logic [3:0] oversample_shift;
        logic [7:0] sample_cycles;
    } atdo_cfg_t;

    typedef struct packed {
        logic eocFlag;
        logic startFlag;
        logic result_overrun_flag;
    } atdo_stat_t;

    typedef struct packed {
        logic tempSensorEn;
        logic vrefEn;
        logic batteryChanEn;
        logic batteryDividerEn;
    } atdo_ana_en_t;

endpackage

/* File: rtl/atdo_trig_sel.sv */
// module: external trigger synchroniser, source select and edge detector
`timescale 1ns/1ps
module atdo_trig_sel
    import atdo_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    // trigger pins and selection
    input  wire logic [SRC_N-1:0]       hwTrig,
    input  wire atdo_pkg::atdo_edge_t   edgeMode,
    input  wire logic [3:0]             srcSel,
    // one-cycle start request
    output logic                        trigEvent
);
    import atdo_pkg::*;

    logic [SRC_N-1:0] meta_q;
    logic [SRC_N-1:0] sync_q;
    logic [SRC_N-1:0] prev_q;
    logic             cur;
    logic             old;

    //==========================================================================
    // two-stage synchroniser plus per-input history
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end
        else
        begin
            meta_q <= hwTrig;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    //==========================================================================
    // history kept per input, so switching source compares like with like
    always_comb
    begin
        cur = sync_q[srcSel];
        old = prev_q[srcSel];
        case (edgeMode)
            EDGE_RISE: trigEvent = cur & ~old;
            EDGE_FALL: trigEvent = ~cur & old;
            EDGE_BOTH: trigEvent = cur ^ old;
            default:   trigEvent = 1'b0;
        endcase
    end

endmodule // atdo_trig_sel

/* File: rtl/atdo_ovs.sv */
// module: oversampling accumulator with right shift, rounding and truncation
`timescale 1ns/1ps
module atdo_ovs
    import atdo_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rstn,
    // control
    input  wire logic              flush,
    input  wire logic [2:0]        ratio,
    input  wire logic [3:0]        shift,
    // raw results in
    input  wire logic              sampleValid,
    input  wire logic [RES_W-1:0]  sample,
    // averaged words out
    output logic                   wordValid,
    output logic [DATA_W-1:0]      word
);
    import atdo_pkg::*;

    logic [ACC_W-1:0]  acc_q, acc_d;
    logic [8:0]        cnt_q, cnt_d;
    logic              valid_q, valid_d;
    logic [DATA_W-1:0] word_q, word_d;
    logic [ACC_W-1:0]  sum;
    logic [ACC_W:0]    rounded;
    logic [3:0]        sh;
    logic [8:0]        lastCnt;

    //==========================================================================
    // accumulate, then shift with round-to-nearest on the final sample
    always_comb
    begin
        sh      = (shift > OVS_SHIFT_MAX) ? OVS_SHIFT_MAX : shift;
        lastCnt = 9'((10'h002 << ratio) - 10'h001);
        sum     = acc_q + {{(ACC_W-RES_W){1'b0}}, sample};
        rounded = {1'b0, sum};
        if (sh != 4'h0)
        begin
            rounded = rounded + ((ACC_W+1)'(1) << (sh - 4'h1));
        end
        rounded = rounded >> sh;
        acc_d   = acc_q;
        cnt_d   = cnt_q;
        valid_d = 1'b0;
        word_d  = word_q;
        if (flush)
        begin
            acc_d = '0;
            cnt_d = '0;
        end
        else if (sampleValid)
        begin
            if (cnt_q == lastCnt)
            begin
                acc_d   = '0;
                cnt_d   = '0;
                valid_d = 1'b1;
                word_d  = rounded[DATA_W-1:0];
            end
            else
            begin
                acc_d = sum;
                cnt_d = cnt_q + 9'h001;
            end
        end
    end

    //==========================================================================
    // state registers
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            acc_q   <= '0;
            cnt_q   <= '0;
            valid_q <= 1'b0;
            word_q  <= DATA_RST;
        end
        else
        begin
            acc_q   <= acc_d;
            cnt_q   <= cnt_d;
            valid_q <= valid_d;
            word_q  <= word_d;
        end
    end

    assign wordValid = valid_q;
    assign word      = word_q;

endmodule // atdo_ovs

/* File: rtl/atdo_top.sv */
// module: converter sequencer, result register, DMA request and overrun control
`timescale 1ns/1ps
module atdo_top
    import atdo_pkg::*;
(
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rstn,

    // configuration from software
    input  wire atdo_pkg::atdo_cfg_t       cfg,

    // software strobes
    input  wire logic                      swTrigger,
    input  wire logic                      eocClear,
    input  wire logic                      overrunClear,
    input  wire logic                      startClear,

    // hardware trigger pins
    input  wire logic [atdo_pkg::SRC_N-1:0] hwTrig,

    // analog macro, same clock
    input  wire logic                      compBit,
    output logic                           sampleHold,
    output logic [atdo_pkg::RES_W-1:0]     sarDac,
    output atdo_pkg::atdo_ana_en_t         anaEn,

    // result register and dma side
    input  wire logic                      dataRead,
    output logic [atdo_pkg::DATA_W-1:0]    resultData,
    output logic                           dmaReq,

    // status and interrupt
    output atdo_pkg::atdo_stat_t           status,
    output logic                           irq
);
    import atdo_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT,
        ST_STALL
    } atdo_state_t;

    //==========================================================================
    // declarations
    atdo_state_t       state_q, state_d;
    logic [7:0]        cnt_q, cnt_d;
    logic [3:0]        bit_q, bit_d;
    logic [RES_W-1:0]  sar_q, sar_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic              unread_q, unread_d;
    logic              eoc_q, eoc_d;
    logic              start_q, start_d;
    logic              ovf_q, ovf_d;
    logic              dma_q, dma_d;
    logic              irq_q, irq_d;
    atdo_ana_en_t      ana_q, ana_d;

    logic              trigEvent;
    logic              startConv;
    logic [7:0]        smplLast;
    logic [3:0]        convCyc;
    logic [3:0]        lastBit;
    logic              convDone;
    logic [RES_W-1:0]  rawResult;
    logic              ovsFlush;
    logic              ovsValid;
    logic [DATA_W-1:0] ovsWord;
    logic              wordValid;
    logic [DATA_W-1:0] word;
    logic              ovfCheck;
    logic              ovfEvent;

    //==========================================================================
    // trigger path
    atdo_trig_sel u_trig (
        .mclk      (mclk),
        .rstn      (rstn),
        .hwTrig    (hwTrig),
        .edgeMode  (cfg.trigger_edge_mode),
        .srcSel    (cfg.trigger_source_select),
        .trigEvent (trigEvent)
    );

    assign startConv = cfg.converter_on & (swTrigger | trigEvent);

    //==========================================================================
    // timing derived from resolution and sample setting
    always_comb
    begin
        // resolution is only legal to change with the converter off
        case (cfg.resolution_select)
            RES_12:  convCyc = CONV_CYC_12;
            RES_10:  convCyc = CONV_CYC_10;
            RES_8:   convCyc = CONV_CYC_8;
            RES_6:   convCyc = CONV_CYC_6;
            default: convCyc = CONV_CYC_12;
        endcase
        lastBit = 4'(RES_W) - convCyc;
        // same sample length for every conversion of an oversampled burst
        if (cfg.sample_cycles < SMPL_MIN_CYC)
        begin
            smplLast = SMPL_MIN_CYC - 8'h01;
        end
        else
        begin
            smplLast = cfg.sample_cycles - 8'h01;
        end
    end

    //==========================================================================
    // successive approximation sequencer
    always_comb
    begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        bit_d     = bit_q;
        sar_d     = sar_q;
        convDone  = 1'b0;
        rawResult = sar_q;
        if (compBit)
        begin
            rawResult[bit_q] = 1'b1;
        end
        else
        begin
            rawResult[bit_q] = 1'b0;
        end
        case (state_q)
            ST_IDLE:
            begin
                if (startConv)
                begin
                    state_d = ST_SAMPLE;
                    cnt_d   = '0;
                end
            end
            ST_SAMPLE:
            begin
                if (cnt_q == smplLast)
                begin
                    state_d = ST_CONVERT;
                    bit_d   = 4'(RES_W - 1);
                    sar_d   = {1'b1, {(RES_W-1){1'b0}}};
                end
                else
                begin
                    cnt_d = cnt_q + 8'h01;
                end
            end
            ST_CONVERT:
            begin
                sar_d = rawResult;
                if (bit_q == lastBit)
                begin
                    convDone = 1'b1;
                    state_d  = ST_IDLE;
                end
                else
                begin
                    bit_d        = bit_q - 4'h1;
                    sar_d[bit_d] = 1'b1;
                end
            end
            ST_STALL:
            begin
                // stays here until software clears the overrun flag
                if (!ovf_q)
                begin
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
        if (ovfEvent)
        begin
            state_d = ST_STALL;
        end
        else if (!cfg.converter_on && state_q != ST_STALL)
        begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
            bit_q   <= '0;
            sar_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            bit_q   <= bit_d;
            sar_q   <= sar_d;
        end
    end

    assign sampleHold = (state_q == ST_SAMPLE);
    assign sarDac     = sar_q;

    //==========================================================================
    // oversampler; low bits past the resolution are already zero
    assign ovsFlush = ovfEvent | ~cfg.converter_on | ~cfg.oversample_enable;

    atdo_ovs u_ovs (
        .mclk        (mclk),
        .rstn        (rstn),
        .flush       (ovsFlush),
        .ratio       (cfg.oversample_ratio),
        .shift       (cfg.oversample_shift),
        .sampleValid (convDone & cfg.oversample_enable),
        .sample      (rawResult),
        .wordValid   (ovsValid),
        .word        (ovsWord)
    );

    //==========================================================================
    // result selection and overrun detection
    always_comb
    begin
        if (cfg.oversample_enable)
        begin
            wordValid = ovsValid;
            word      = ovsWord;
        end
        else
        begin
            wordValid = convDone;
            word      = {{(DATA_W-RES_W){1'b0}}, rawResult};
        end
        ovfCheck = cfg.dma_enable | cfg.eoc_mode_select;
        ovfEvent = wordValid & ovfCheck & unread_q & ~dataRead;
    end

    //==========================================================================
    // flags, data register and dma request; every hardware set beats a clear
    always_comb
    begin
        data_d   = data_q;
        unread_d = unread_q & ~dataRead;
        eoc_d    = eoc_q & ~eocClear & ~dataRead;
        start_d  = (start_q & ~startClear) | (state_q == ST_IDLE && startConv);
        ovf_d    = ovf_q & ~overrunClear;
        dma_d    = 1'b0;
        if (ovfEvent)
        begin
            // newest result dropped so unread data survives
            ovf_d = 1'b1;
        end
        else if (wordValid)
        begin
            data_d   = word;
            unread_d = 1'b1;
            eoc_d    = 1'b1;
            dma_d    = cfg.dma_enable;
        end
        irq_d = ovf_d & cfg.overrun_irq_enable;
        ana_d.tempSensorEn     = cfg.internal_channels_enable;
        ana_d.vrefEn           = cfg.internal_channels_enable;
        ana_d.batteryChanEn    = cfg.battery_channel_enable;
        ana_d.batteryDividerEn = cfg.battery_channel_enable;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            data_q   <= DATA_RST;
            unread_q <= 1'b0;
            eoc_q    <= 1'b0;
            start_q  <= 1'b0;
            ovf_q    <= 1'b0;
            dma_q    <= 1'b0;
            irq_q    <= 1'b0;
            ana_q    <= '0;
        end
        else
        begin
            data_q   <= data_d;
            unread_q <= unread_d;
            eoc_q    <= eoc_d;
            start_q  <= start_d;
            ovf_q    <= ovf_d;
            dma_q    <= dma_d;
            irq_q    <= irq_d;
            ana_q    <= ana_d;
        end
    end

    //==========================================================================
    // outputs, all from flops
    assign resultData                 = data_q;
    assign dmaReq                     = dma_q;
    assign irq                        = irq_q;
    assign anaEn                      = ana_q;
    assign status.eocFlag             = eoc_q;
    assign status.startFlag           = start_q;
    assign status.result_overrun_flag = ovf_q;

endmodule // atdo_top

/* File: dv/atdo_top_assertions.sv */
// checker: port assertions for the converter control top
`timescale 1ns/1ps
module atdo_top_assertions
    import atdo_pkg::*;
(
    // clock and reset
    input wire logic                      mclk,
    input wire logic                      rstn,
    // watched ports
    input wire atdo_pkg::atdo_cfg_t       cfg,
    input wire logic                      overrunClear,
    input wire logic                      sampleHold,
    input wire atdo_pkg::atdo_ana_en_t    anaEn,
    input wire logic [atdo_pkg::DATA_W-1:0] resultData,
    input wire logic                      dmaReq,
    input wire atdo_pkg::atdo_stat_t      status,
    input wire logic                      irq
);
    //==========
    // helpers
    logic        ovf;
    logic [1:0]  dma_channel_enable;
    logic [15:0] lowMask;
    // bits a plain result must leave clear; averaged words use all 16
    assign ovf     = status.result_overrun_flag;
    assign dma_channel_enable    = {cfg.internal_channels_enable, cfg.battery_channel_enable};
    assign lowMask = cfg.oversample_enable ? 16'h0000
                   : {4'hF, ~(12'hFFF << {cfg.resolution_select, 1'b0})};
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    //==========
    // assertions
    a_dma_pulse: assert property (dmaReq |-> $past(cfg.dma_enable) ##1 !dmaReq)
        else $error("dma request not a single gated pulse");
    a_ovf_gated: assert property ($rose(ovf) |-> $past(cfg.dma_enable || cfg.eoc_mode_select))
        else $error("overrun raised while checking is off");
    a_ovf_irq: assert property (ovf && $past(cfg.overrun_irq_enable) |-> irq)
        else $error("overrun interrupt missing");
    a_irq_cause: assert property (irq |-> ovf && $past(cfg.overrun_irq_enable))
        else $error("interrupt without enabled overrun");
    a_ovf_keeps: assert property ($rose(ovf) |-> $stable(resultData) && !dmaReq)
        else $error("overrun overwrote unread data");
    a_ovf_sticky: assert property (ovf && !overrunClear |=> ovf)
        else $error("overrun flag dropped without clear");
    a_stall_idle: assert property (ovf |-> !sampleHold)
        else $error("sampling during overrun stall");
    a_res_zero: assert property ($changed(resultData) |-> !(|(resultData & lowMask)))
        else $error("unused result bits not zero");
    a_smp_min: assert property ($rose(sampleHold) |-> sampleHold[*3])
        else $error("sample phase shorter than minimum");
    a_conv_min: assert property ($fell(sampleHold) |-> !sampleHold[*6])
        else $error("conversion phase too short");
    a_ana_follow: assert property (1'b1 |=> anaEn == {{2{$past(dma_channel_enable[1])}}, {2{$past(dma_channel_enable[0])}}})
        else $error("analog enables do not follow channel bits");
    //==========
    // coverage
    c_overrun: cover property ($rose(ovf));
    c_dma: cover property (dmaReq);
    c_ovs_word: cover property ($rose(status.eocFlag) && cfg.oversample_enable);
endmodule // atdo_top_assertions

bind atdo_top atdo_top_assertions atdo_top_assertions_inst (.mclk, .rstn, .cfg,
    .overrunClear, .sampleHold, .anaEn, .resultData, .dmaReq, .status, .irq);

/* File: dv/atdo_dma_model.sv */
// DMA controller model: one read of the result register per request
`timescale 1ns/1ps
module atdo_dma_model
    import atdo_pkg::*;
(
    // clock and reset
    input wire logic                      mclk,
    input wire logic                      rstn,
    // bench control
    input wire logic                      halt,
    input wire logic [3:0]                delay,
    // converter side
    input wire logic                      dmaReq,
    input wire logic [atdo_pkg::DATA_W-1:0] resultData,
    output logic                          dataRead,
    output logic                          rdValid,
    output logic [atdo_pkg::DATA_W-1:0]   rdData
);
    int   waitCnt;
    logic pend;
    // a halted channel ignores requests, leaving the data unread
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pend <= 1'b0;
            waitCnt <= 0;
            dataRead <= 1'b0;
            rdValid <= 1'b0;
            rdData <= '0;
        end
        else
        begin
            dataRead <= 1'b0;
            rdValid <= 1'b0;
            if (dmaReq && !halt)
            begin
                pend <= 1'b1;
                waitCnt <= delay;
            end
            else if (pend && waitCnt == 0)
            begin
                pend <= 1'b0;
                dataRead <= 1'b1;
                rdValid <= 1'b1;
                rdData <= resultData;
            end
            else if (pend)
                waitCnt <= waitCnt - 1;
        end
    end
endmodule // atdo_dma_model

/* File: dv/atdo_top_tb_top.sv */
// testbench: stimulus, reference values and verdict for the converter top
`timescale 1ns/1ps
module atdo_top_tb_top;
    import atdo_pkg::*;
    logic         mclk, rstn, swTrigger, eocClear, overrunClear, startClear;
    logic         swRead, dmaRead, halt, rdValid, sampleHold, dmaReq, irq;
    logic [3:0]   delay;
    logic [15:0]  hwTrig, resultData, rdData;
    logic [11:0]  vin, sarDac;
    logic [31:0]  rnd;
    atdo_cfg_t    cfg;
    atdo_ana_en_t anaEn;
    atdo_stat_t   status;
    int           error_cnt, compares;
    logic [15:0]  gotQ[$], expQ[$];
    wire          dataRead = swRead | dmaRead;
    wire          compBit  = (vin >= sarDac);
    //==========
    // clock, design, partner
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    atdo_top atdo_top_inst (.mclk, .rstn, .cfg, .swTrigger, .eocClear, .overrunClear,
        .startClear, .hwTrig, .compBit, .sampleHold, .sarDac, .anaEn, .dataRead,
        .resultData, .dmaReq, .status, .irq);
    atdo_dma_model atdo_dma_model_inst (.mclk, .rstn, .halt, .delay, .dmaReq, .resultData,
        .dataRead(dmaRead), .rdValid, .rdData);
    // reads the partner completed, in order
    always @(posedge mclk)
        if (rdValid === 1'b1)
            gotQ.push_back(rdData);
    //==========
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one software start; flag timing only meaningful on plain shots
    task automatic conv(input logic [11:0] v, input bit tm);
        int s;
        cyc(1);
        s = (cfg.sample_cycles < 3) ? 3 : cfg.sample_cycles;
        vin <= v;
        swTrigger <= 1'b1;
        cyc(1);
        swTrigger <= 1'b0;
        cyc(s + 11 - 2 * cfg.resolution_select);
        @(negedge mclk);
        if (tm) chk(status.eocFlag, 0);
        cyc(1);
        @(negedge mclk);
        if (tm) chk(status.eocFlag, 1);
    endtask
    // averages n samples; word expected once, rounded half up
    task automatic ovs(input logic [2:0] ra, input logic [3:0] sh, input bit full);
        longint sum, half;
        int n;
        sum = 0;
        half = 0;
        n = 2 << ra;
        if (sh != 0) half = 1 << (sh - 1);
        cyc(1);
        cfg.converter_on <= 1'b0;
        cfg.resolution_select <= RES_12;
        cfg.oversample_enable <= 1'b1;
        {cfg.oversample_ratio, cfg.oversample_shift} <= {ra, sh};
        swRead <= 1'b1;
        cyc(1);
        swRead <= 1'b0;
        cfg.converter_on <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            rnd = lfsr(rnd);
            if (full) rnd[11:0] = 12'hFFF;
            sum += rnd[11:0];
            conv(rnd[11:0], 0);
            if (i < n - 1) chk(status.eocFlag, 0);
        end
        cyc(2);
        @(negedge mclk);
        chk(resultData, 32'(((sum + half) >> sh) & 64'hFFFF));
    endtask
    //==========
    // watchdog
    initial
    begin
        cyc(40000);
        error_cnt++;
        complete_run();
    end
    //==========
    // main sequence
    initial
    begin
        {rstn, swTrigger, eocClear, overrunClear, startClear, swRead, halt} = '0;
        {cfg, hwTrig, vin, delay} = '0;
        rnd = 32'hCF8F5183;
        error_cnt = 0;
        compares = 0;
        cyc(6);
        rstn <= 1'b1;
        cfg.converter_on <= 1'b1;
        cfg.overrun_irq_enable <= 1'b1;
        // each resolution, changed with the converter off
        for (int r = 0; r < 4; r++)
        begin
            cyc(1);
            cfg.converter_on <= 1'b0;
            cfg.resolution_select <= atdo_res_t'(r);
            cfg.sample_cycles <= {5'h00, rnd[2:0]};
            cyc(1);
            cfg.converter_on <= 1'b1;
            rnd = lfsr(rnd);
            conv(rnd[11:0], 1);
            chk(resultData, rnd[11:0] & (12'hFFF << 2 * r));
            cyc(1);
            if (r[0]) swRead <= 1'b1; else eocClear <= 1'b1;
            cyc(1);
            {swRead, eocClear} <= 2'b00;
            @(negedge mclk);
            chk(status.eocFlag, 0);
        end
        // unread data: overrun only with dma or eoc mode, then stall and recovery
        halt <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            cyc(1);
            {cfg.dma_enable, cfg.eoc_mode_select} <= k[1:0];
            conv(12'h123, 0);
            conv(12'h456, 0);
            cyc(2);
            @(negedge mclk);
            chk(status.result_overrun_flag, k != 0);
            chk(resultData, (k ? 12'h123 : 12'h456) & 12'hFC0);
            chk(irq, k != 0);
            cyc(1);
            {startClear, swTrigger} <= 2'b11;
            cyc(1);
            {startClear, swTrigger} <= 2'b00;
            cyc(4);
            @(negedge mclk);
            chk(status.startFlag, k == 0);
            cyc(1);
            cfg.dma_enable <= 1'b0;
            cyc(1);
            cfg.converter_on <= 1'b0;
            cyc(1);
            overrunClear <= 1'b1;
            cyc(1);
            overrunClear <= 1'b0;
            cfg.converter_on <= 1'b1;
            swRead <= 1'b1;
            cyc(1);
            swRead <= 1'b0;
            cyc(20);
        end
        // dma stream with prompt and slow reads
        halt <= 1'b0;
        cfg.dma_enable <= 1'b1;
        cfg.eoc_mode_select <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            delay <= {1'b0, rnd[14:12]};
            expQ.push_back({4'h0, rnd[11:0] & 12'hFC0});
            conv(rnd[11:0], 1);
        end
        cyc(12);
        chk(gotQ.size(), 6);
        while (gotQ.size() > 0 && expQ.size() > 0)
            chk(gotQ.pop_front(), expQ.pop_front());
        // every source and edge mode; noise on other pins starts nothing
        cfg.dma_enable <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            cyc(1);
            hwTrig <= '0;
            cyc(4);
            cfg.trigger_edge_mode <= atdo_edge_t'(i % 4);
            cfg.trigger_source_select <= i[3:0];
            cyc(4);
            for (int p = 0; p < 3; p++)
            begin
                rnd = lfsr(rnd);
                startClear <= 1'b1;
                hwTrig <= p ? hwTrig ^ (16'h1 << i) : rnd[15:0] & ~(16'h1 << i);
                cyc(1);
                startClear <= 1'b0;
                cyc(7);
                @(negedge mclk);
                chk(status.startFlag, p ? i[p - 1] : 0);
                cyc(24);
            end
        end
        // moving the source to a pin at another level starts nothing
        hwTrig <= 16'h0020;
        cyc(6);
        startClear <= 1'b1;
        cfg.trigger_source_select <= 4'h5;
        cyc(1);
        startClear <= 1'b0;
        cyc(6);
        @(negedge mclk);
        chk(status.startFlag, 0);
        // analog enables follow the channel bits
        for (int j = 0; j < 4; j++)
        begin
            cyc(1);
            {cfg.internal_channels_enable, cfg.battery_channel_enable} <= j[1:0];
            cyc(2);
            @(negedge mclk);
            chk(anaEn, {{2{j[1]}}, {2{j[0]}}});
        end
        ovs(3'h0, 4'h1, 1'b0);
        ovs(3'h2, 4'h3, 1'b0);
        ovs(3'h4, 4'h0, 1'b1);
        ovs(3'h7, 4'h8, 1'b1);
        complete_run();
    end
endmodule // atdo_top_tb_top
